// [verilog/sstu_consts.svh]
// constants for the state save tracking unit
`ifndef SSTU_CONSTS_SVH
`define SSTU_CONSTS_SVH

// component indices
`define SSTU_C_X87       6'h00
`define SSTU_C_SSE       6'h01
`define SSTU_C_UPPER     6'h02
`define SSTU_C_BOUND     6'h03
`define SSTU_C_BOUND_CSR 6'h04
`define SSTU_C_OPMASK    6'h05
`define SSTU_C_WIDE_HI   6'h06
`define SSTU_C_HI16      6'h07
`define SSTU_C_TRACE     6'h08
`define SSTU_C_PKEY      6'h09
`define SSTU_C_DUTY      6'h0D
`define SSTU_C_LAST      6'h3E

// initial values
`define SSTU_VCS_RESET   32'h0000_1F80
`define SSTU_X87_CW_INIT 16'h037F
`define SSTU_X87_SW_INIT 16'h0000
`define SSTU_X87_TW_INIT 16'hFFFF
`define SSTU_X87_SEL_INIT 16'h0000

// save area alignment (64 bytes)
`define SSTU_ALIGN_MASK  64'h0000_0000_0000_003F

// extended control read selectors
`define SSTU_SEL_MASK    32'h0000_0000
`define SSTU_SEL_INUSE   32'h0000_0001

`endif

// [verilog/sstu_pkg.sv]
// types for the state save tracking unit
package sstu_pkg;

	typedef enum logic [2:0] {
		SSTU_IDLE   = 3'b000,
		SSTU_HDR_RD = 3'b001,
		SSTU_HDR_WR = 3'b010,
		SSTU_VCS    = 3'b011,
		SSTU_COMP   = 3'b100
	} sstu_state_type;

	typedef enum logic [1:0] {
		SSTU_OP_HDR_READ  = 2'b00,
		SSTU_OP_HDR_WRITE = 2'b01,
		SSTU_OP_VCS_STORE = 2'b10,
		SSTU_OP_COMP_STORE = 2'b11
	} sstu_mem_op_type;

	typedef enum logic [1:0] {
		SSTU_SAVE_OPT  = 2'b00,
		SSTU_SAVE_CMP  = 2'b01,
		SSTU_SAVE_SUP  = 2'b10
	} sstu_save_kind_type;

endpackage : sstu_pkg

// [verilog/sstu_tracker.sv]
// state component tracking and full state save sequencing
`timescale 1ns/10ps
`include "sstu_consts.svh"

//Contract
//- optimized, compacted, supervisor saves skip components known initial.
//- unmodified skipping only for the save area of the latest restore.
//- full save uses no optimization; compacted save uses init only.
//- without tracking, in-use and modified bitmaps read all ones.
//- in-use 0 means definitely initial; 1 allowed when initial.
//- control read selector 1 returns enabled mask AND in-use, in two halves.
//- selector 1 forces bit 1 when mask bit 1 set and vector control not reset.
//- modified 0 means definitely unchanged since last restore.
//- each restore records privilege, non-root, area address, compaction vector.
//- modified skipping only when all four record items match.
//- x87 initial only with fixed control, status, tag, zero pointers and stack.
//- legacy vectors initial when regs 0-15 zero in 64-bit, else 0-7.
//- upper halves (256 and 512 bit) follow the same mode rule.
//- high sixteen vectors initial when zero in 64-bit, always outside.
//- bound, bound csr, masks, trace, key, duty initial when all zero.
//- faults in order invalid opcode, device unavailable, misalignment.
//- requested bitmap is enabled mask AND instruction mask.
//- header vector bits: unrequested kept, requested take in-use bit.
//- full save writes only the header state vector of the header.
//- full save stores every requested component 0 to 62 (bit 63 never stored), standard format.
//- vector control and mask stored when requested bit 1 or 2 set.
//- restore sets in-use on requested and present; modified on unrequested.
module sstu_tracker (
	// clock and reset
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_rstn,
	// configuration
	input  wire logic                          i_init_opt_en,
	input  wire logic                          i_mod_opt_en,
	input  wire logic [63:0]                   i_enabled_component_mask,
	input  wire logic                          i_os_save_enable,
	input  wire logic                          i_task_switched_flag,
	input  wire logic                          i_long_mode,
	input  wire logic [1:0]                    i_privilege_level,
	input  wire logic                          i_nonroot,
	input  wire logic [31:0]                   i_vector_control_status,
	// register contents
	input  wire logic [15:0]                   i_x87_control_word,
	input  wire logic [15:0]                   i_x87_status_word,
	input  wire logic [15:0]                   i_x87_tag_word,
	input  wire logic [15:0]                   i_x87_code_sel,
	input  wire logic [15:0]                   i_x87_data_sel,
	input  wire logic [63:0]                   i_x87_instr_ptr,
	input  wire logic [63:0]                   i_x87_data_ptr,
	input  wire logic [7:0]                    i_x87_stack_nz,
	input  wire logic [15:0]                   i_vec_nz,
	input  wire logic [15:0]                   i_upper_nz,
	input  wire logic [15:0]                   i_wide_upper_nz,
	input  wire logic [15:0]                   i_high_sixteen_nz,
	input  wire logic [3:0]                    i_bound_nz,
	input  wire logic [1:0]                    i_bound_csr_nz,
	input  wire logic [7:0]                    i_opmask_nz,
	input  wire logic [8:0]                    i_trace_nz,
	input  wire logic                          i_pkey_nz,
	input  wire logic                          i_duty_nz,
	// component register writes
	input  wire logic [63:0]                   i_comp_write,
	// restore
	input  wire logic                          i_rst_valid,
	input  wire logic [63:0]                   i_rst_mask,
	input  wire logic [63:0]                   i_rst_state_vec,
	input  wire logic [63:0]                   i_rst_comp_vec,
	input  wire logic [63:0]                   i_rst_addr,
	// optimized, compacted, supervisor save query
	input  wire logic                          i_osave_valid,
	input  sstu_pkg::sstu_save_kind_type       i_osave_kind,
	input  wire logic [63:0]                   i_osave_mask,
	input  wire logic [63:0]                   i_osave_addr,
	input  wire logic [63:0]                   i_osave_comp_vec,
	output logic                               o_osave_done,
	output logic [63:0]                        o_osave_bitmap,
	output logic                               o_osave_mod_used,
	// extended control read
	input  wire logic                          i_xcr_read,
	input  wire logic [31:0]                   i_xcr_sel,
	output logic                               o_xcr_done,
	output logic [31:0]                        o_xcr_lo,
	output logic [31:0]                        o_xcr_hi,
	// full state save command
	input  wire logic                          i_fsave_valid,
	input  wire logic [63:0]                   i_fsave_mask,
	input  wire logic [63:0]                   i_fsave_addr,
	output logic                               o_fsave_ready,
	output logic                               o_fsave_done,
	output logic                               o_fault_ud,
	output logic                               o_fault_nm,
	output logic                               o_fault_gp,
	// save area memory port
	output logic                               o_mem_valid,
	output sstu_pkg::sstu_mem_op_type          o_mem_op,
	output logic [63:0]                        o_mem_addr,
	output logic [5:0]                         o_mem_comp,
	output logic [63:0]                        o_mem_wdata,
	input  wire logic                          i_mem_ready,
	input  wire logic [63:0]                   i_mem_rdata,
	// tracking state
	output logic [63:0]                        o_in_use_bitmap,
	output logic [63:0]                        o_modified_bitmap
);

	logic [63:0]              comp_init;
	logic [63:0]              inuse_q;
	logic [63:0]              modified_q;
	logic [63:0]              inuse_eff;
	logic [63:0]              mod_eff;
	logic                     rec_valid_q;
	logic [1:0]               rec_priv_q;
	logic                     rec_nonroot_q;
	logic [63:0]              rec_addr_q;
	logic [63:0]              rec_comp_q;
	logic [63:0]              rst_requested_component_bitmap;
	logic [63:0]              osave_requested_component_bitmap;
	logic                     rec_match;
	logic [63:0]              xcr_inuse;
	sstu_pkg::sstu_state_type state_q;
	logic [63:0]              requested_component_bitmap_q;
	logic [63:0]              snap_inuse_q;
	logic [63:0]              base_q;
	logic [63:0]              hdr_q;
	logic [5:0]               idx_q;
	logic                     fsave_take;

	// which components currently hold their initial configuration
	always_comb begin
		comp_init = 64'h0000_0000_0000_0000;
		comp_init[`SSTU_C_X87] = (i_x87_control_word == `SSTU_X87_CW_INIT) &&
			(i_x87_status_word == `SSTU_X87_SW_INIT) && (i_x87_tag_word == `SSTU_X87_TW_INIT) &&
			(i_x87_code_sel == `SSTU_X87_SEL_INIT) && (i_x87_data_sel == `SSTU_X87_SEL_INIT) &&
			(i_x87_instr_ptr == 64'h0) && (i_x87_data_ptr == 64'h0) && (i_x87_stack_nz == 8'h00);
		comp_init[`SSTU_C_SSE] = i_long_mode ? (i_vec_nz == 16'h0000)
			: (i_vec_nz[7:0] == 8'h00);
		comp_init[`SSTU_C_UPPER] = i_long_mode ? (i_upper_nz == 16'h0000)
			: (i_upper_nz[7:0] == 8'h00);
		comp_init[`SSTU_C_WIDE_HI] = i_long_mode ? (i_wide_upper_nz == 16'h0000)
			: (i_wide_upper_nz[7:0] == 8'h00);
		comp_init[`SSTU_C_HI16] = !i_long_mode || (i_high_sixteen_nz == 16'h0000);
		comp_init[`SSTU_C_BOUND] = (i_bound_nz == 4'h0);
		comp_init[`SSTU_C_BOUND_CSR] = (i_bound_csr_nz == 2'h0);
		comp_init[`SSTU_C_OPMASK] = (i_opmask_nz == 8'h00);
		comp_init[`SSTU_C_TRACE] = (i_trace_nz == 9'h000);
		comp_init[`SSTU_C_PKEY] = !i_pkey_nz;
		comp_init[`SSTU_C_DUTY] = !i_duty_nz;
	end

	assign rst_requested_component_bitmap = i_enabled_component_mask & i_rst_mask;
	assign osave_requested_component_bitmap = i_enabled_component_mask & i_osave_mask;

	// in-use tracking; a set always beats the clear from the init detector
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			inuse_q <= 64'hFFFF_FFFF_FFFF_FFFF;
		end else begin
			inuse_q <= ~comp_init
				| i_comp_write
				| (i_rst_valid ? (rst_requested_component_bitmap & i_rst_state_vec) : 64'h0);
		end
	end

	// modified tracking
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			modified_q <= 64'hFFFF_FFFF_FFFF_FFFF;
		end else if (i_rst_valid) begin
			modified_q <= ~rst_requested_component_bitmap | i_comp_write;
		end else begin
			modified_q <= modified_q | i_comp_write;
		end
	end

	// no tracking hardware: everything in use and modified
	assign inuse_eff = i_init_opt_en ? inuse_q : 64'hFFFF_FFFF_FFFF_FFFF;
	assign mod_eff = i_mod_opt_en ? modified_q : 64'hFFFF_FFFF_FFFF_FFFF;
	assign o_in_use_bitmap = inuse_eff;
	assign o_modified_bitmap = mod_eff;

	// last restore record
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rec_valid_q <= 1'b0;
			rec_priv_q <= 2'h0;
			rec_nonroot_q <= 1'b0;
			rec_addr_q <= 64'h0;
			rec_comp_q <= 64'h0;
		end else if (i_rst_valid) begin
			rec_valid_q <= 1'b1;
			rec_priv_q <= i_privilege_level;
			rec_nonroot_q <= i_nonroot;
			rec_addr_q <= i_rst_addr;
			rec_comp_q <= i_rst_comp_vec;
		end
	end

	assign rec_match = rec_valid_q && i_mod_opt_en &&
		(rec_priv_q == i_privilege_level) && (rec_nonroot_q == i_nonroot) &&
		(rec_addr_q == i_osave_addr) && (rec_comp_q == i_osave_comp_vec);

	// components an optimized, compacted or supervisor save must write
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_osave_done <= 1'b0;
			o_osave_bitmap <= 64'h0;
			o_osave_mod_used <= 1'b0;
		end else begin
			o_osave_done <= i_osave_valid;
			if (i_osave_valid) begin
				if (i_osave_kind != sstu_pkg::SSTU_SAVE_CMP && rec_match) begin
					o_osave_bitmap <= osave_requested_component_bitmap & inuse_eff & mod_eff;
					o_osave_mod_used <= 1'b1;
				end else begin
					o_osave_bitmap <= osave_requested_component_bitmap & inuse_eff;
					o_osave_mod_used <= 1'b0;
				end
			end
		end
	end

	// extended control read
	assign xcr_inuse = (i_enabled_component_mask & inuse_eff)
		| {62'h0, i_enabled_component_mask[1]
		&& (i_vector_control_status != `SSTU_VCS_RESET), 1'b0};

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_xcr_done <= 1'b0;
			o_xcr_lo <= 32'h0;
			o_xcr_hi <= 32'h0;
		end else begin
			o_xcr_done <= i_xcr_read;
			if (i_xcr_read) begin
				if (i_xcr_sel == `SSTU_SEL_INUSE) begin
					o_xcr_lo <= xcr_inuse[31:0];
					o_xcr_hi <= xcr_inuse[63:32];
				end else if (i_xcr_sel == `SSTU_SEL_MASK) begin
					o_xcr_lo <= i_enabled_component_mask[31:0];
					o_xcr_hi <= i_enabled_component_mask[63:32];
				end else begin
					o_xcr_lo <= 32'h0;
					o_xcr_hi <= 32'h0;
				end
			end
		end
	end

	// full state save: fault checks then sequence
	assign o_fsave_ready = (state_q == sstu_pkg::SSTU_IDLE);
	assign fsave_take = i_fsave_valid && o_fsave_ready;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_fault_ud <= 1'b0;
			o_fault_nm <= 1'b0;
			o_fault_gp <= 1'b0;
		end else begin
			o_fault_ud <= fsave_take && !i_os_save_enable;
			o_fault_nm <= fsave_take && i_os_save_enable && i_task_switched_flag;
			o_fault_gp <= fsave_take && i_os_save_enable && !i_task_switched_flag &&
				((i_fsave_addr & `SSTU_ALIGN_MASK) != 64'h0);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state_q <= sstu_pkg::SSTU_IDLE;
			requested_component_bitmap_q <= 64'h0;
			snap_inuse_q <= 64'h0;
			base_q <= 64'h0;
			hdr_q <= 64'h0;
			idx_q <= 6'h00;
			o_fsave_done <= 1'b0;
		end else begin
			o_fsave_done <= 1'b0;
			unique case (state_q)
				sstu_pkg::SSTU_IDLE: begin
					if (fsave_take && i_os_save_enable && !i_task_switched_flag &&
						((i_fsave_addr & `SSTU_ALIGN_MASK) == 64'h0)) begin
						requested_component_bitmap_q <= i_enabled_component_mask & i_fsave_mask;
						snap_inuse_q <= inuse_eff;
						base_q <= i_fsave_addr;
						idx_q <= 6'h00;
						state_q <= sstu_pkg::SSTU_HDR_RD;
					end
				end
				sstu_pkg::SSTU_HDR_RD: begin
					if (i_mem_ready) begin
						hdr_q <= (i_mem_rdata & ~requested_component_bitmap_q) | (snap_inuse_q & requested_component_bitmap_q);
						state_q <= sstu_pkg::SSTU_HDR_WR;
					end
				end
				sstu_pkg::SSTU_HDR_WR: begin
					if (i_mem_ready) begin
						state_q <= (requested_component_bitmap_q[1] || requested_component_bitmap_q[2]) ? sstu_pkg::SSTU_VCS
							: sstu_pkg::SSTU_COMP;
					end
				end
				sstu_pkg::SSTU_VCS: begin
					if (i_mem_ready) begin
						state_q <= sstu_pkg::SSTU_COMP;
					end
				end
				sstu_pkg::SSTU_COMP: begin
					if (!requested_component_bitmap_q[idx_q] || i_mem_ready) begin
						if (idx_q == `SSTU_C_LAST) begin
							o_fsave_done <= 1'b1;
							state_q <= sstu_pkg::SSTU_IDLE;
						end else begin
							idx_q <= idx_q + 6'h01;
						end
					end
				end
				default: begin
					state_q <= sstu_pkg::SSTU_IDLE;
				end
			endcase
		end
	end

	// memory requests; only the header state vector is written in the header
	assign o_mem_valid = (state_q == sstu_pkg::SSTU_HDR_RD)
		|| (state_q == sstu_pkg::SSTU_HDR_WR) || (state_q == sstu_pkg::SSTU_VCS)
		|| ((state_q == sstu_pkg::SSTU_COMP) && requested_component_bitmap_q[idx_q]);
	assign o_mem_op = (state_q == sstu_pkg::SSTU_HDR_WR) ? sstu_pkg::SSTU_OP_HDR_WRITE
		: (state_q == sstu_pkg::SSTU_VCS) ? sstu_pkg::SSTU_OP_VCS_STORE
		: (state_q == sstu_pkg::SSTU_COMP) ? sstu_pkg::SSTU_OP_COMP_STORE
		: sstu_pkg::SSTU_OP_HDR_READ;

	assign o_mem_addr = base_q;
	assign o_mem_comp = idx_q;
	assign o_mem_wdata = hdr_q;

endmodule : sstu_tracker

// [verification/sstu_tracker_chk.sv]
// assertions on the state save tracking unit ports
`timescale 1ns/10ps
`include "sstu_consts.svh"
module sstu_tracker_chk (
	// clock, reset and controls
	input wire logic        i_sys_clk, i_rstn, i_fsave_valid, o_fsave_ready,
	input wire logic        i_os_save_enable, i_task_switched_flag, i_init_opt_en, i_mod_opt_en,
	// events
	input wire logic        o_fault_ud, o_fault_nm, o_fault_gp, o_mem_valid, i_xcr_read,
	input wire logic        o_xcr_done, i_osave_valid, o_osave_done, o_osave_mod_used,
	// data
	input wire logic [63:0] i_fsave_addr, i_enabled_component_mask, o_in_use_bitmap,
	input wire logic [63:0] o_modified_bitmap, i_osave_mask, o_osave_bitmap,
	input wire logic [31:0] i_xcr_sel, o_xcr_lo, o_xcr_hi, i_vector_control_status,
	input sstu_pkg::sstu_mem_op_type    o_mem_op,
	input sstu_pkg::sstu_save_kind_type i_osave_kind
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	logic take;
	logic bad;
	assign take = i_fsave_valid && o_fsave_ready;
	assign bad = !i_os_save_enable || i_task_switched_flag || i_fsave_addr[5:0] != 6'h00;
	fault_ud_a: assert property (
		take && !i_os_save_enable |=> o_fault_ud && !o_fault_nm && !o_fault_gp)
		else $error("invalid opcode fault missing");
	fault_nm_a: assert property (
		take && i_os_save_enable && i_task_switched_flag |=> o_fault_nm && !o_fault_ud && !o_fault_gp)
		else $error("device unavailable fault missing");
	fault_gp_a: assert property (
		take && i_os_save_enable && !i_task_switched_flag && i_fsave_addr[5:0] != 6'h00
		|=> o_fault_gp && !o_fault_ud && !o_fault_nm) else $error("alignment fault missing");
	fault_quiet_a: assert property (take && bad |=> !o_mem_valid [*2])
		else $error("memory touched by faulting save");
	hdr_first_a: assert property (
		take && !bad |=> o_mem_valid && o_mem_op == sstu_pkg::SSTU_OP_HDR_READ && !o_fault_gp)
		else $error("save does not start with header read");
	inuse_off_a: assert property (!i_init_opt_en && $past(!i_init_opt_en) |-> &o_in_use_bitmap)
		else $error("in-use bitmap not all ones");
	mod_off_a: assert property (!i_mod_opt_en && $past(!i_mod_opt_en) |-> &o_modified_bitmap)
		else $error("modified bitmap not all ones");
	xcr_use_a: assert property (i_xcr_read && i_xcr_sel == 32'h1 |=> o_xcr_done &&
		{o_xcr_hi, o_xcr_lo} == ($past(i_enabled_component_mask & o_in_use_bitmap) | {62'h0,
		$past(i_enabled_component_mask[1] && i_vector_control_status != `SSTU_VCS_RESET), 1'b0}))
		else $error("control read value wrong");
	cmp_init_a: assert property (
		i_osave_valid && i_osave_kind == sstu_pkg::SSTU_SAVE_CMP |=> o_osave_done && !o_osave_mod_used
		&& o_osave_bitmap == $past(i_osave_mask & i_enabled_component_mask & o_in_use_bitmap))
		else $error("compacted save bitmap wrong");
	cover property (o_fault_gp);
	cover property (o_mem_valid && o_mem_op == sstu_pkg::SSTU_OP_VCS_STORE);
	cover property (o_osave_mod_used);
endmodule : sstu_tracker_chk

// [verification/sstu_mem_model.sv]
// save area memory with random stalls
`timescale 1ns/10ps
module sstu_mem_model (
	input  wire logic        i_clk, i_clr, i_valid,
	input  sstu_pkg::sstu_mem_op_type i_op,
	input  wire logic [5:0]  i_comp,
	input  wire logic [63:0] i_wdata, i_hdr_init,
	output logic             o_ready, o_vcs,
	output logic [63:0]      o_rdata, o_hdr, o_stored
);
	// data off the bus while not ready is scrambled
	assign o_rdata = o_ready ? o_hdr : ~o_hdr;
	initial o_ready = 1'b0;
	always @(posedge i_clk) begin
		o_ready <= ($urandom % 3) != 0;
		if (i_clr) begin
			o_hdr <= i_hdr_init;
			o_stored <= '0;
			o_vcs <= 1'b0;
		end else if (i_valid && o_ready) begin
			case (i_op)
				sstu_pkg::SSTU_OP_HDR_WRITE: o_hdr <= i_wdata;
				sstu_pkg::SSTU_OP_VCS_STORE: o_vcs <= 1'b1;
				sstu_pkg::SSTU_OP_COMP_STORE: o_stored[i_comp] <= 1'b1;
				default: ;
			endcase
		end
	end
endmodule : sstu_mem_model

// [verification/sstu_tracker_test.sv]
// self-checking bench for the state save tracking unit
`timescale 1ns/10ps
`include "sstu_consts.svh"
module sstu_tracker_test;
	logic i_sys_clk = 0, i_rstn = 0, i_init_opt_en = 1, i_mod_opt_en = 1, i_os_save_enable = 1;
	logic i_task_switched_flag = 0, i_long_mode = 1, i_nonroot = 0, i_pkey_nz = 0, i_duty_nz = 0;
	logic i_rst_valid = 0, i_osave_valid = 0, i_xcr_read = 0, i_fsave_valid = 0, mclr = 0;
	logic [1:0]  i_privilege_level = 0, i_bound_csr_nz = 0;
	logic [3:0]  i_bound_nz = 0;
	logic [7:0]  i_x87_stack_nz = 0, i_opmask_nz = 0;
	logic [8:0]  i_trace_nz = 0;
	logic [15:0] i_x87_control_word = 0, i_x87_status_word = 0, i_x87_tag_word = 0;
	logic [15:0] i_x87_code_sel = 0, i_x87_data_sel = 0, i_vec_nz = 0, i_upper_nz = 0;
	logic [15:0] i_wide_upper_nz = 0, i_high_sixteen_nz = 0;
	logic [31:0] i_vector_control_status = 0, i_xcr_sel = 32'h1;
	logic [63:0] i_enabled_component_mask = '1, i_x87_instr_ptr = 0, i_x87_data_ptr = 0;
	logic [63:0] i_comp_write = 0, i_rst_mask = 0, i_rst_state_vec = 0, i_rst_comp_vec = 0;
	logic [63:0] i_rst_addr = 64'h1000, i_osave_mask = 0, i_osave_addr = 0, i_osave_comp_vec = 0;
	logic [63:0] i_fsave_mask = 0, i_fsave_addr = 0, h0 = 0;
	sstu_pkg::sstu_save_kind_type i_osave_kind = sstu_pkg::SSTU_SAVE_OPT;
	logic        i_mem_ready, o_osave_done, o_osave_mod_used, o_xcr_done, o_fsave_ready;
	logic        o_fsave_done, o_fault_ud, o_fault_nm, o_fault_gp, o_mem_valid, mvcs;
	logic [5:0]  o_mem_comp;
	logic [31:0] o_xcr_lo, o_xcr_hi;
	logic [63:0] i_mem_rdata, o_osave_bitmap, o_mem_addr, o_mem_wdata, o_in_use_bitmap;
	logic [63:0] o_modified_bitmap, mhdr, mst, rf, ei, rm;
	sstu_pkg::sstu_mem_op_type o_mem_op;
	int num_errors = 0, n_tests = 0, k, j;
	sstu_tracker DUT (.*);
	sstu_mem_model mem (.i_clk(i_sys_clk), .i_clr(mclr), .i_valid(o_mem_valid), .i_op(o_mem_op),
		.i_comp(o_mem_comp), .i_wdata(o_mem_wdata), .i_hdr_init(h0), .o_ready(i_mem_ready),
		.o_vcs(mvcs), .o_rdata(i_mem_rdata), .o_hdr(mhdr), .o_stored(mst));
	always #20 i_sys_clk = ~i_sys_clk;
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	// one rare single-bit change away from v
	function automatic logic [63:0] pk(input logic [63:0] v);
		return ($urandom % 4 == 0) ? v ^ (64'h1 << ($urandom % 16)) : v;
	endfunction : pk
	function automatic logic [63:0] exp_init();
		logic [63:0] e;
		logic [15:0] m;
		e = '0;
		m = i_long_mode ? 16'hFFFF : 16'h00FF;
		e[0] = i_x87_control_word === `SSTU_X87_CW_INIT && i_x87_status_word === '0
			&& i_x87_tag_word === `SSTU_X87_TW_INIT && (i_x87_code_sel | i_x87_data_sel) === '0
			&& (i_x87_instr_ptr | i_x87_data_ptr) === '0 && i_x87_stack_nz === '0;
		e[1] = (i_vec_nz & m) === '0;
		e[2] = (i_upper_nz & m) === '0;
		e[6] = (i_wide_upper_nz & m) === '0;
		e[7] = !i_long_mode || i_high_sixteen_nz === '0;
		e[3] = i_bound_nz === '0;
		e[4] = i_bound_csr_nz === '0;
		e[5] = i_opmask_nz === '0;
		e[8] = i_trace_nz === '0;
		e[9] = !i_pkey_nz;
		e[13] = !i_duty_nz;
		return e;
	endfunction : exp_init
	task automatic fsave();
		logic [2:0] ef;
		ef = !i_os_save_enable ? 3'h4 : i_task_switched_flag ? 3'h2
			: i_fsave_addr[5:0] != 0 ? 3'h1 : 3'h0;
		rf = i_fsave_mask & i_enabled_component_mask;
		mclr = 1;
		i_fsave_valid = 1;
		@(posedge i_sys_clk) #1 mclr = 0;
		i_fsave_valid = 0;
		for (k = 0; k < 600 && o_fsave_done !== 1'b1
			&& {o_fault_ud, o_fault_nm, o_fault_gp} === 3'h0; k++) begin
			if (o_mem_valid === 1'b1) chk("adr", o_mem_addr, i_fsave_addr);
			@(posedge i_sys_clk) #1;
		end
		chk("end", k < 600, 1);
		chk("flt", {o_fault_ud, o_fault_nm, o_fault_gp}, ef);
		chk("hdr", mhdr, ef ? h0 : h0 & ~rf | ~ei & rf);
		chk("st", mst, ef ? '0 : rf & 64'h7FFF_FFFF_FFFF_FFFF);
		chk("vcs", mvcs, !ef && (rf[1] || rf[2]));
	endtask : fsave
	initial begin
		void'($urandom(35256));
		repeat (3) @(posedge i_sys_clk);
		#1 chk("rst", o_in_use_bitmap & o_modified_bitmap, '1);
		i_rstn = 1;
		for (j = 0; j < 40; j++) begin
			i_long_mode = $urandom;
			i_x87_control_word = pk(16'h037F);
			i_x87_status_word = pk('0);
			i_x87_tag_word = pk(16'hFFFF);
			i_x87_code_sel = pk('0);
			i_x87_data_sel = pk('0);
			i_x87_instr_ptr = pk('0);
			i_x87_data_ptr = pk('0);
			i_x87_stack_nz = pk('0);
			i_vec_nz = pk('0);
			i_upper_nz = pk('0);
			i_wide_upper_nz = pk('0);
			i_high_sixteen_nz = pk('0);
			i_bound_nz = pk('0);
			i_bound_csr_nz = pk('0);
			i_opmask_nz = pk('0);
			i_trace_nz = pk('0);
			i_pkey_nz = pk('0);
			i_duty_nz = pk('0);
			i_enabled_component_mask = {$urandom, $urandom};
			i_vector_control_status = ($urandom % 2) ? 32'h1F80 : $urandom;
			repeat (3) @(posedge i_sys_clk);
			#1 ei = exp_init();
			chk("use", o_in_use_bitmap, ~ei);
			i_xcr_sel = j % 3;
			i_xcr_read = 1;
			@(posedge i_sys_clk) #1 i_xcr_read = 0;
			rm = i_enabled_component_mask & ~ei | {62'h0,
				i_enabled_component_mask[1] && i_vector_control_status != 32'h1F80, 1'b0};
			if (j % 3 == 0) rm = i_enabled_component_mask;
			else if (j % 3 == 2) rm = '0;
			chk("xcr", {o_xcr_hi, o_xcr_lo}, rm);
			i_os_save_enable = $urandom % 8 != 0;
			i_task_switched_flag = $urandom % 8 == 0;
			i_fsave_addr = {$urandom, $urandom} & ~64'h3F | ($urandom % 8 == 0);
			i_fsave_mask = j == 3 ? 64'h4 : j == 4 ? '1 : {$urandom, $urandom};
			if (j < 3) begin
				i_os_save_enable = j != 0;
				i_task_switched_flag = j == 1;
				i_fsave_addr[0] = j == 2;
			end
			h0 = {$urandom, $urandom};
			fsave();
		end
		i_enabled_component_mask = '1;
		rm = {$urandom, $urandom};
		i_rst_mask = rm;
		i_rst_state_vec = {$urandom, $urandom};
		i_rst_valid = 1;
		@(posedge i_sys_clk) #1 i_rst_valid = 0;
		chk("ru", o_in_use_bitmap, ~ei | rm & i_rst_state_vec);
		i_comp_write = 64'h1 << 20;
		@(posedge i_sys_clk) #1 i_comp_write = '0;
		@(posedge i_sys_clk) #1 rm = ~rm | 64'h1 << 20;
		chk("mod", o_modified_bitmap, rm);
		ei = exp_init();
		// optimized, compacted and supervisor saves only probed as a query, never relied on by software
		for (j = 0; j < 7; j++) begin
			i_osave_kind = j == 5 ? sstu_pkg::SSTU_SAVE_CMP
				: j == 6 ? sstu_pkg::SSTU_SAVE_SUP : sstu_pkg::SSTU_SAVE_OPT;
			i_osave_mask = '1;
			i_osave_addr = j == 1 ? 64'h1040 : 64'h1000;
			i_osave_comp_vec = j == 2;
			i_privilege_level = j == 3;
			i_nonroot = j == 4;
			i_osave_valid = 1;
			@(posedge i_sys_clk) #1 i_osave_valid = 0;
			chk("mu", o_osave_mod_used, j == 0 || j == 6);
			chk("ob", o_osave_bitmap, ~ei & (j == 0 || j == 6 ? rm : '1));
		end
		i_init_opt_en = 0;
		i_mod_opt_en = 0;
		repeat (2) @(posedge i_sys_clk);
		#1 chk("off", o_in_use_bitmap & o_modified_bitmap, '1);
		final_report();
	end
	initial begin
		#1000000;
		num_errors++;
		final_report();
	end
endmodule : sstu_tracker_test
bind sstu_tracker sstu_tracker_chk chk_i (.*);
